// ==== hw/pcw_window_mapper.sv ====
/*
  One slot of the host-to-card window mapper: register file, memory and
  I/O window decode, card enables, wait insertion and supply controls.
  Assumes host commands, addresses and card inputs are synchronous to
  ref_clk and that the host holds its command until ready returns high.
*/
`timescale 1ns/1ps
module pcw_window_mapper
  import pcw_pkg::*;
#(
  parameter int NUM_MEM_WIN = 5,
  parameter int NUM_IO_WIN = 2
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic reg_wr,
  input wire logic [5:0] reg_index,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic [23:0] sys_addr,
  input wire logic sbhe_n,
  input wire logic card_wait_n,
  input wire logic card_io_width16_n,
  output logic [25:0] card_addr,
  output logic card_low_byte_enable_n,
  output logic card_high_byte_enable_n,
  output logic card_attr_sel_n,
  output logic card_oe_n,
  output logic card_we_n,
  output logic card_iord_n,
  output logic card_iowr_n,
  output logic host_channel_ready,
  output logic zero_wait_out_n,
  output logic socket_supply_ctl0,
  output logic socket_supply_ctl1,
  output logic prog_voltage_ctl0,
  output logic prog_voltage_ctl1
);

  logic [7:0] regs_r [0:REG_COUNT-1];
  pcw_state_type state_r;
  logic [WAIT_W-1:0] wait_cnt_r;
  logic cur_io_r;

  wire cmd_any = mem_rd | mem_wr | io_rd | io_wr;
  wire is_io = io_rd | io_wr;
  wire address_bit_zero = sys_addr[0];
  wire [11:0] sys_page = sys_addr[23:12];
  wire [15:0] sys_io = sys_addr[15:0];
  wire [7:0] win_en = regs_r[IDX_WIN_EN];
  wire io_mode = regs_r[IDX_IGC][IGC_IO_MODE];
  wire [7:0] io_ctl = regs_r[IDX_IO_CTL];

  // Per-window decode
  logic [NUM_MEM_WIN-1:0] mem_hit;
  logic [NUM_MEM_WIN-1:0] mem_attr;
  logic [7:0] mem_cfg [NUM_MEM_WIN];
  logic [13:0] mem_page [NUM_MEM_WIN];
  logic [NUM_IO_WIN-1:0] io_hit;
  logic [NUM_IO_WIN-1:0] io_d16;
  logic [3:0] io_cfg [NUM_IO_WIN];

  genvar g;
  generate
    for (g = 0; g < NUM_MEM_WIN; g++) begin : g_mem
      localparam int MB = int'(IDX_MEM_BASE) + int'(MEM_STRIDE) * g;
      wire [11:0] pg_start = {regs_r[MB+MW_START_HI][3:0], regs_r[MB+MW_START_LO]};
      wire [11:0] pg_stop = {regs_r[MB+MW_STOP_HI][3:0], regs_r[MB+MW_STOP_LO]};
      wire [13:0] pg_off = {regs_r[MB+MW_OFF_HI][5:0], regs_r[MB+MW_OFF_LO]};
      // 12-bit page index of 4KB pages bounds one window at 16MB
      assign mem_hit[g] = win_en[g] & (sys_page >= pg_start) & (sys_page <= pg_stop);
      // Offset add wraps in the 64MB card space
      assign mem_page[g] = 14'({2'b00, sys_page} + pg_off);
      assign mem_cfg[g] = regs_r[MB+MW_START_HI];
      assign mem_attr[g] = regs_r[MB+MW_OFF_HI][OH_ATTR];
    end
    for (g = 0; g < NUM_IO_WIN; g++) begin : g_io
      localparam int IB = int'(IDX_IO_BASE) + int'(IO_STRIDE) * g;
      wire [15:0] io_start = {regs_r[IB+IW_START_HI], regs_r[IB+IW_START_LO]};
      wire [15:0] io_stop = {regs_r[IB+IW_STOP_HI], regs_r[IB+IW_STOP_LO]};
      // Byte-exact compare over the full 16-bit space
      assign io_hit[g] = win_en[WEN_IO_LSB+g] & io_mode
                         & (sys_io >= io_start) & (sys_io <= io_stop);
      assign io_cfg[g] = io_ctl[IOC_NIB*g +: IOC_NIB];
      assign io_d16[g] = io_cfg[g][IOC_AUTO] ? ~card_io_width16_n
                                             : io_cfg[g][IOC_DATA16];
    end
  endgenerate

  // Overlapping windows: lowest index wins
  logic sel_hit;
  logic [13:0] sel_page;
  logic sel_d16;
  logic sel_zws;
  logic [WAIT_W-1:0] sel_wait;
  logic sel_attr;

  always_comb begin
    sel_hit = 1'b0;
    sel_page = '0;
    sel_d16 = 1'b0;
    sel_zws = 1'b0;
    sel_wait = '0;
    sel_attr = 1'b0;
    if (is_io) begin
      for (int i = NUM_IO_WIN - 1; i >= 0; i--) begin
        if (io_hit[i]) begin
          sel_hit = 1'b1;
          sel_d16 = io_d16[i];
          sel_zws = io_cfg[i][IOC_ZWS];
          sel_wait = {{(WAIT_W-1){1'b0}}, io_cfg[i][IOC_WAIT]};
        end
      end
    end else begin
      for (int i = NUM_MEM_WIN - 1; i >= 0; i--) begin
        if (mem_hit[i]) begin
          sel_hit = 1'b1;
          sel_page = mem_page[i];
          sel_d16 = mem_cfg[i][SH_DATA16];
          sel_zws = mem_cfg[i][SH_ZWS];
          sel_wait = mem_cfg[i][SH_WAIT_LSB +: WAIT_W];
          sel_attr = mem_attr[i];
        end
      end
    end
  end

  wire start_cycle = (state_r == ST_IDLE) & cmd_any & sel_hit;

  // 8-bit: even enable only; 16-bit: host picks lanes with bit 0 and SBHE
  wire ce_low_nxt = sel_d16 & address_bit_zero;
  wire ce_high_nxt = sel_d16 ? sbhe_n : 1'b1;
  wire attr_nxt = is_io ? 1'b0 : ~sel_attr;
  wire [7:0] status = {5'h00, cur_io_r, state_r != ST_IDLE, ~card_wait_n};

  // Register file
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs_r[i] <= REG_RESET;
      end
    end else if (reg_wr && reg_index != IDX_STATUS) begin
      regs_r[reg_index] <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= REG_RESET;
    end else begin
      reg_rdata <= (reg_index == IDX_STATUS) ? status : regs_r[reg_index];
    end
  end

  // Supply controls are plain register copies; external switches do the sequencing
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      socket_supply_ctl0 <= 1'b0;
      socket_supply_ctl1 <= 1'b0;
      prog_voltage_ctl0 <= 1'b0;
      prog_voltage_ctl1 <= 1'b0;
    end else begin
      socket_supply_ctl0 <= regs_r[IDX_VOLT][VOLT_CTL0];
      socket_supply_ctl1 <= regs_r[IDX_VOLT][VOLT_CTL1];
      prog_voltage_ctl0 <= regs_r[IDX_VPP][VPP_CTL0];
      prog_voltage_ctl1 <= regs_r[IDX_VPP][VPP_CTL1];
    end
  end

  // Cycle sequencer
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_IDLE;
      wait_cnt_r <= '0;
      cur_io_r <= 1'b0;
      card_addr <= '0;
      card_low_byte_enable_n <= 1'b1;
      card_high_byte_enable_n <= 1'b1;
      card_attr_sel_n <= 1'b1;
      card_oe_n <= 1'b1;
      card_we_n <= 1'b1;
      card_iord_n <= 1'b1;
      card_iowr_n <= 1'b1;
      host_channel_ready <= 1'b1;
      zero_wait_out_n <= 1'b1;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (start_cycle) begin
            cur_io_r <= is_io;
            card_addr <= is_io ? {10'h000, sys_io} : {sel_page, sys_addr[11:0]};
            card_low_byte_enable_n <= ce_low_nxt;
            card_high_byte_enable_n <= ce_high_nxt;
            card_attr_sel_n <= attr_nxt;
            card_oe_n <= ~mem_rd;
            card_we_n <= ~mem_wr;
            card_iord_n <= ~io_rd;
            card_iowr_n <= ~io_wr;
            zero_wait_out_n <= ~sel_zws;
            wait_cnt_r <= sel_wait;
            if (sel_wait != '0) begin
              state_r <= ST_WAITC;
              host_channel_ready <= 1'b0;
            end else begin
              state_r <= ST_HOLD;
            end
          end
        end
        ST_WAITC: begin
          wait_cnt_r <= wait_cnt_r - 1'b1;
          if (wait_cnt_r == {{(WAIT_W-1){1'b0}}, 1'b1}) begin
            if (card_wait_n) begin
              state_r <= ST_HOLD;
              host_channel_ready <= 1'b1;
            end else begin
              state_r <= ST_CARDW;
            end
          end
        end
        ST_CARDW: begin
          // Card drops wait: release the host
          if (card_wait_n) begin
            state_r <= ST_HOLD;
            host_channel_ready <= 1'b1;
          end
        end
        ST_HOLD: begin
          if (!cmd_any) begin
            state_r <= ST_IDLE;
            card_low_byte_enable_n <= 1'b1;
            card_high_byte_enable_n <= 1'b1;
            card_attr_sel_n <= 1'b1;
            card_oe_n <= 1'b1;
            card_we_n <= 1'b1;
            card_iord_n <= 1'b1;
            card_iowr_n <= 1'b1;
            zero_wait_out_n <= 1'b1;
          end else if (!card_wait_n) begin
            state_r <= ST_CARDW;
            host_channel_ready <= 1'b0;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence mem_start_s;
    start_cycle && !is_io;
  endsequence

  sequence io_start_s;
    start_cycle && is_io;
  endsequence

  supply_follow_a: assert property (
    ##1 (socket_supply_ctl0 == $past(regs_r[IDX_VOLT][VOLT_CTL0])
      && socket_supply_ctl1 == $past(regs_r[IDX_VOLT][VOLT_CTL1])))
    else $error("supply outputs differ from voltage control register");

  vpp_follow_a: assert property (
    ##1 (prog_voltage_ctl0 == $past(regs_r[IDX_VPP][VPP_CTL0])
      && prog_voltage_ctl1 == $past(regs_r[IDX_VPP][VPP_CTL1])))
    else $error("vpp outputs differ from power control register");

  mem_wait_two_a: assert property (
    (mem_start_s and (sel_wait == 2'd2)) |=> !host_channel_ready ##1 !host_channel_ready
      ##1 (host_channel_ready || !$past(card_wait_n)))
    else $error("memory wait count not honoured");

  card_wait_a: assert property (
    (state_r == ST_HOLD && cmd_any && !card_wait_n) |=> !host_channel_ready)
    else $error("ready not dropped on card wait");

  card_release_a: assert property (
    (state_r == ST_CARDW && card_wait_n) |=> host_channel_ready)
    else $error("ready not restored after card wait");

  zero_wait_a: assert property (
    (mem_start_s and sel_zws) |=> !zero_wait_out_n)
    else $error("zero wait output not asserted");

  window_off_a: assert property (
    (!is_io && win_en[NUM_MEM_WIN-1:0] == '0) |-> !sel_hit)
    else $error("disabled memory window decoded");

  io_window_off_a: assert property (
    (is_io && win_en[WEN_IO_LSB +: NUM_IO_WIN] == '0) |-> !sel_hit)
    else $error("disabled io window decoded");

  mem_ce_eight_a: assert property (
    (mem_start_s and !sel_d16) |=> !card_low_byte_enable_n && card_high_byte_enable_n)
    else $error("8-bit memory card enables wrong");

  io_ce_word_a: assert property (
    (io_start_s and sel_d16 && !sbhe_n && !address_bit_zero)
      |=> !card_low_byte_enable_n && !card_high_byte_enable_n)
    else $error("16-bit io card enables wrong");

  card_addr_a: assert property (
    mem_start_s |=> card_addr[11:0] == $past(sys_addr[11:0])
      && card_addr[25:12] == $past(sel_page))
    else $error("card address not offset page plus host low bits");

  io_strobe_a: assert property (
    (io_start_s and io_rd) |=> !card_iord_n && !card_attr_sel_n && card_oe_n && card_we_n)
    else $error("io read strobes wrong");

endmodule

// ==== hw/pcw_pkg.sv ====
/*
  Constants for the per-slot PC card window mapper: register indices,
  field positions, reset values and cycle states.
  Assumes one slot per mapper instance; indices are the slot-relative ones.
*/
package pcw_pkg;

  // Register indices within one slot
  localparam logic [5:0] IDX_STATUS = 6'h01;
  localparam logic [5:0] IDX_VPP = 6'h02;
  localparam logic [5:0] IDX_IGC = 6'h03;
  localparam logic [5:0] IDX_WIN_EN = 6'h06;
  localparam logic [5:0] IDX_IO_CTL = 6'h07;
  localparam logic [5:0] IDX_IO_BASE = 6'h08;
  localparam logic [5:0] IO_STRIDE = 6'h04;
  localparam logic [5:0] IDX_MEM_BASE = 6'h10;
  localparam logic [5:0] MEM_STRIDE = 6'h08;
  localparam logic [5:0] IDX_VOLT = 6'h17;
  localparam int REG_COUNT = 64;
  localparam logic [7:0] REG_RESET = 8'h00;

  // Byte positions inside a memory window group
  localparam int MW_START_LO = 0;
  localparam int MW_START_HI = 1;
  localparam int MW_STOP_LO = 2;
  localparam int MW_STOP_HI = 3;
  localparam int MW_OFF_LO = 4;
  localparam int MW_OFF_HI = 5;
  // Byte positions inside an I/O window group
  localparam int IW_START_LO = 0;
  localparam int IW_START_HI = 1;
  localparam int IW_STOP_LO = 2;
  localparam int IW_STOP_HI = 3;

  // Field positions
  localparam int SH_DATA16 = 7;
  localparam int SH_ZWS = 6;
  localparam int SH_WAIT_LSB = 4;
  localparam int WAIT_W = 2;
  localparam int OH_ATTR = 6;
  localparam int IGC_IO_MODE = 5;
  localparam int WEN_IO_LSB = 6;
  localparam int IOC_NIB = 4;
  localparam int IOC_DATA16 = 0;
  localparam int IOC_AUTO = 1;
  localparam int IOC_ZWS = 2;
  localparam int IOC_WAIT = 3;
  localparam int VPP_CTL0 = 0;
  localparam int VPP_CTL1 = 1;
  localparam int VOLT_CTL0 = 0;
  localparam int VOLT_CTL1 = 1;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAITC = 2'b01,
    ST_CARDW = 2'b10,
    ST_HOLD = 2'b11
  } pcw_state_type;

endpackage

// ==== sim/pcw_card_model.sv ====
/*
  Card at the far side of one slot: wait request and 16-bit I/O flag.
  Assumes the bench sets wait_len and io16 between host cycles.
*/
`timescale 1ns/1ps
module pcw_card_model (
  input wire logic ref_clk,
  input wire logic card_oe_n,
  input wire logic card_we_n,
  input wire logic card_iord_n,
  input wire logic card_iowr_n,
  input wire logic [3:0] wait_len,
  input wire logic io16,
  output logic card_wait_n,
  output logic card_io_width16_n
);
  logic act_r;
  logic [3:0] cnt_r;
  wire act = !(card_oe_n && card_we_n && card_iord_n && card_iowr_n);
  initial begin
    act_r = 1'b0;
    cnt_r = 4'h0;
  end
  // Wait starts on the first strobe cycle only, like a slow card access
  always @(negedge ref_clk) begin
    if (act && !act_r) begin
      cnt_r <= wait_len;
    end else if (cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
    end
    act_r <= act;
  end
  assign card_wait_n = (cnt_r == 4'h0);
  // Static decode: the card claims 16-bit I/O for its whole range
  assign card_io_width16_n = ~io16;
endmodule

// ==== sim/pcw_window_mapper_bench.sv ====
/*
  Self-checking bench for the window mapper: registers, memory and I/O
  windows, card enables, waits and supply outputs.
  Assumes the card model answers on the card side of the slot.
*/
`timescale 1ns/1ps
module pcw_window_mapper_bench;
  import pcw_pkg::*;
  logic ref_clk, nrst, reg_wr, mem_rd, mem_wr, io_rd, io_wr, sbhe_n;
  logic [5:0] reg_index;
  logic [7:0] reg_wdata, reg_rdata, snap;
  logic [23:0] sys_addr;
  logic [25:0] card_addr, caddr;
  logic card_wait_n, card_io_width16_n, cel_n, ceh_n, attr_n, oe_n, we_n, iord_n, iowr_n;
  logic rdy, zw_n, sup0, sup1, pv0, pv1, io16, at, zw, d16;
  logic [3:0] wait_len;
  logic [1:0] wt;
  logic [11:0] sp;
  logic [13:0] off;
  logic [5:0] base;
  int err_count, cmp_count, nlow;

  pcw_window_mapper pcw_window_mapper_inst (.ref_clk(ref_clk), .nrst(nrst), .reg_wr(reg_wr),
    .reg_index(reg_index), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .io_rd(io_rd), .io_wr(io_wr), .sys_addr(sys_addr), .sbhe_n(sbhe_n),
    .card_wait_n(card_wait_n), .card_io_width16_n(card_io_width16_n), .card_addr(card_addr),
    .card_low_byte_enable_n(cel_n), .card_high_byte_enable_n(ceh_n),
    .card_attr_sel_n(attr_n), .card_oe_n(oe_n), .card_we_n(we_n), .card_iord_n(iord_n),
    .card_iowr_n(iowr_n), .host_channel_ready(rdy), .zero_wait_out_n(zw_n),
    .socket_supply_ctl0(sup0), .socket_supply_ctl1(sup1), .prog_voltage_ctl0(pv0),
    .prog_voltage_ctl1(pv1));

  pcw_card_model pcw_card_model_inst (.ref_clk(ref_clk), .card_oe_n(oe_n), .card_we_n(we_n),
    .card_iord_n(iord_n), .card_iowr_n(iowr_n), .wait_len(wait_len), .io16(io16),
    .card_wait_n(card_wait_n), .card_io_width16_n(card_io_width16_n));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    reg_index = i;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    // One idle edge keeps the strobe from being set twice in one time step
    @(negedge ref_clk);
  endtask

  task automatic rd_chk(input logic [5:0] i, input logic [7:0] e);
    reg_index = i;
    @(negedge ref_clk);
    check(reg_rdata, e);
  endtask

  // Snapshot order: ce low, ce high, attr, oe, we, iord, iowr, zero-wait
  task automatic host_cycle(input logic [3:0] cmd, input logic [23:0] a, input logic hb);
    {mem_rd, mem_wr, io_rd, io_wr} = cmd;
    sys_addr = a;
    sbhe_n = hb;
    // Outputs launch at the first edge; ready may already be low there
    @(negedge ref_clk);
    snap = {cel_n, ceh_n, attr_n, oe_n, we_n, iord_n, iowr_n, zw_n};
    caddr = card_addr;
    nlow = 0;
    while (rdy !== 1'b1 && nlow < 50) begin
      nlow++;
      @(negedge ref_clk);
    end
    {mem_rd, mem_wr, io_rd, io_wr} = 4'h0;
    repeat (2) @(negedge ref_clk);
    check(oe_n & we_n & iord_n & iowr_n, 1'b1);
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Whole run is a few hundred cycles; this leaves a wide margin
  initial begin
    #100000;
    err_count++;
    tally_and_finish;
  end

  initial begin
    {nrst, reg_wr, mem_rd, mem_wr, io_rd, io_wr, sbhe_n, io16} = 8'h02;
    reg_index = 6'h00;
    reg_wdata = 8'h00;
    sys_addr = 24'h000000;
    wait_len = 4'h0;
    err_count = 0;
    cmp_count = 0;
    repeat (20) @(negedge ref_clk);
    nrst = 1'b1;
    check({sup0, sup1, pv0, pv1, rdy}, 5'h01);
    rd_chk(IDX_WIN_EN, REG_RESET);
    rd_chk(IDX_IO_CTL, REG_RESET);
    wr(IDX_VOLT, 8'h03);
    wr(IDX_VPP, 8'h02);
    repeat (2) @(negedge ref_clk);
    check({sup0, sup1}, 2'b11);
    check({pv0, pv1}, 2'b01);
    rd_chk(IDX_VOLT, 8'h03);
    $display("test registers done");

    // Five windows with differing wait, width, space and zero-wait settings
    for (int i = 0; i < 5; i++) begin
      sp = 12'(i * 32 + 16);
      off = 14'(i * 3 + 1);
      base = 6'(IDX_MEM_BASE + MEM_STRIDE * i);
      wr(base, sp[7:0]);
      wr(base + 6'h01, {i < 3, i == 4, 2'(i % 4), sp[11:8]});
      wr(base + 6'h02, 8'(sp + 12'd15));
      wr(base + 6'h03, {4'h0, 4'((sp + 12'd15) >> 8)});
      wr(base + 6'h04, off[7:0]);
      wr(base + 6'h05, {1'b0, i % 2 == 1, off[13:8]});
    end
    wr(IDX_WIN_EN, 8'h1f);
    for (int i = 0; i < 5; i++) begin
      sp = 12'(i * 32 + 16);
      off = 14'(i * 3 + 1);
      at = (i % 2 == 1);
      wt = 2'(i % 4);
      zw = (i == 4);
      d16 = (i < 3);
      host_cycle(4'h8, {sp, 12'h001}, 1'b0);
      check(snap, {d16 ? 2'b10 : 2'b01, ~at, 4'b0111, ~zw});
      check(caddr, {14'({2'b00, sp} + off), 12'h001});
      check(nlow, 32'(wt));
      host_cycle(4'h4, {12'(sp + 12'd15), 12'hfff}, 1'b1);
      check(snap[7:3], {d16 ? 2'b11 : 2'b01, ~at, 2'b10});
      check(caddr, {14'({2'b00, sp} + off + 14'd15), 12'hfff});
    end
    host_cycle(4'h8, 24'h020000, 1'b0);
    check(snap[4:1], 4'hf);
    wait_len = 4'h5;
    host_cycle(4'h8, 24'h050000, 1'b0);
    check(nlow >= 5, 1'b1);
    wait_len = 4'h0;
    wr(IDX_WIN_EN, 8'h1e);
    host_cycle(4'h8, 24'h010000, 1'b0);
    check(snap[4:1], 4'hf);
    $display("test memory windows done");

    // I/O window 0: card width pin and one wait; window 1: 8-bit, zero-wait
    io16 = 1'b1;
    wr(IDX_IGC, 8'h20);
    wr(IDX_IO_BASE, 8'h00);
    wr(IDX_IO_BASE + 6'h01, 8'h03);
    wr(IDX_IO_BASE + 6'h02, 8'h0f);
    wr(IDX_IO_BASE + 6'h03, 8'h03);
    wr(IDX_IO_BASE + IO_STRIDE, 8'h00);
    wr(IDX_IO_BASE + IO_STRIDE + 6'h01, 8'hf4);
    wr(IDX_IO_BASE + IO_STRIDE + 6'h02, 8'hff);
    wr(IDX_IO_BASE + IO_STRIDE + 6'h03, 8'hf4);
    wr(IDX_IO_CTL, 8'h4a);
    wr(IDX_WIN_EN, 8'hc0);
    host_cycle(4'h2, 24'h000300, 1'b0);
    check(snap, 8'h1b);
    check(nlow, 32'd1);
    host_cycle(4'h1, 24'h00030f, 1'b0);
    check(snap, 8'h9d);
    host_cycle(4'h2, 24'h00f4ff, 1'b0);
    check(snap, 8'h5a);
    check(nlow, 32'd0);
    host_cycle(4'h2, 24'h000310, 1'b0);
    check(snap[4:1], 4'hf);
    wr(IDX_WIN_EN, 8'h40);
    host_cycle(4'h2, 24'h00f400, 1'b0);
    check(snap[4:1], 4'hf);
    wr(IDX_IGC, 8'h00);
    host_cycle(4'h2, 24'h000300, 1'b0);
    check(snap[4:1], 4'hf);
    $display("test io windows done");
    tally_and_finish;
  end
endmodule
